/* File: src/mipb_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module mipb_axil_slave (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Write address and data
	input  wire logic [mipb_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [mipb_pkg::DATA_W-1:0]   wdata,
	input  wire logic [mipb_pkg::STRB_W-1:0]   wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	// Write response
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	// Read
	input  wire logic [mipb_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [mipb_pkg::DATA_W-1:0]        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	// Register side
	output logic                               wr_en,
	output logic [mipb_pkg::ADDR_W-1:0]        wr_addr,
	output logic [mipb_pkg::DATA_W-1:0]        wr_data,
	output logic [mipb_pkg::STRB_W-1:0]        wr_strb,
	input  wire logic                          wr_err,
	output logic                               rd_en,
	output logic [mipb_pkg::ADDR_W-1:0]        rd_addr,
	input  wire logic [mipb_pkg::DATA_W-1:0]   rd_data,
	input  wire logic                          rd_err
);

	typedef struct packed {
		logic [mipb_pkg::ADDR_W-1:0] awaddr;
		logic                        aw_got;
		logic [mipb_pkg::DATA_W-1:0] wdata;
		logic [mipb_pkg::STRB_W-1:0] wstrb;
		logic                        w_got;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [mipb_pkg::DATA_W-1:0] rdata;
		logic [1:0]                  rresp;
	} mipb_axil_st_t;

	mipb_axil_st_t st_r;
	mipb_axil_st_t st_nxt;

	// ==========================================================================
	// Handshakes
	// Address and data may arrive in either order; the write commits once both are held.
	always_comb begin
		st_nxt  = st_r;
		awready = ~st_r.aw_got & ~st_r.bvalid;
		wready  = ~st_r.w_got & ~st_r.bvalid;
		arready = ~st_r.rvalid;
		wr_en   = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
		wr_addr = st_r.awaddr;
		wr_data = st_r.wdata;
		wr_strb = st_r.wstrb;
		rd_en   = arvalid & ~st_r.rvalid;
		rd_addr = araddr;
		if (awvalid & awready) begin
			st_nxt.awaddr = awaddr;
			st_nxt.aw_got = 1'b1;
		end
		if (wvalid & wready) begin
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
			st_nxt.w_got = 1'b1;
		end
		if (wr_en) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = wr_err ? mipb_pkg::RESP_SLVERR : mipb_pkg::RESP_OKAY;
		end else if (st_r.bvalid & bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (rd_en) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd_data;
			st_nxt.rresp  = rd_err ? mipb_pkg::RESP_SLVERR : mipb_pkg::RESP_OKAY;
		end else if (st_r.rvalid & rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bvalid = st_r.bvalid;
	assign bresp  = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rdata  = st_r.rdata;
	assign rresp  = st_r.rresp;

endmodule

`default_nettype wire

/* File: src/mipb_io_port.sv */
`timescale 1ns/10ps
`default_nettype none

// Function
// - Every pin except the input-only pin of port 1 has its own direction bit, 0 for input and 1 for a driving output.
// - The input-only pin of port 1 always reads 1 in its direction bit, whatever is written.
// - Writing 1 into a write-only pull-up bit switches that pin's internal pull-up on.
// - The input-only pin has no pull-up and its pull-up bit stays fixed at 0.
// - Bit 0 of the open-drain control register turns port 1 pin 0 into an open-drain output.
// - The input-only pin's data bit is read-only and reads 1 when external reset is selected.
// - Direction registers accept single-bit set and clear without touching the other bits.
// - A data write, bit set or bit clear sets the level driven on pins that are outputs.
// - Reading a data register returns the present state of that port's pins.
module mipb_io_port (
	// Clock and reset
	input  wire logic                                  aclk,
	input  wire logic                                  aresetn,
	// AXI4-Lite write address and data
	input  wire logic [mipb_pkg::ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	input  wire logic [mipb_pkg::DATA_W-1:0]           s_axi_wdata,
	input  wire logic [mipb_pkg::STRB_W-1:0]           s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                                 s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	// AXI4-Lite read
	input  wire logic [mipb_pkg::ADDR_W-1:0]           s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	output logic [mipb_pkg::DATA_W-1:0]                s_axi_rdata,
	output logic [1:0]                                 s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	// Configuration option
	input  wire logic                                  ext_reset_option,
	// Port 0 pads
	input  wire logic [mipb_pkg::PORT0_PINS-1:0]       port0_pad_in,
	output logic [mipb_pkg::PORT0_PINS-1:0]            port0_pad_out,
	output logic [mipb_pkg::PORT0_PINS-1:0]            port0_pad_oe,
	output logic [mipb_pkg::PORT0_PINS-1:0]            port0_pullup_on,
	// Port 1 pads; pin 5 is input only
	input  wire logic [mipb_pkg::PORT1_PINS-1:0]       port1_pad_in,
	output logic [mipb_pkg::PORT1_DRV_PINS-1:0]        port1_pad_out,
	output logic [mipb_pkg::PORT1_DRV_PINS-1:0]        port1_pad_oe,
	output logic [mipb_pkg::PORT1_DRV_PINS-1:0]        port1_pullup_on,
	// Port 5 pads
	input  wire logic [mipb_pkg::PORT5_PINS-1:0]       port5_pad_in,
	output logic [mipb_pkg::PORT5_PINS-1:0]            port5_pad_out,
	output logic [mipb_pkg::PORT5_PINS-1:0]            port5_pad_oe,
	output logic [mipb_pkg::PORT5_PINS-1:0]            port5_pullup_on
);

	// ==========================================================================
	// State
	// Only implemented bits are stored; fixed bits are inserted when read.
	typedef struct packed {
		logic [7:0] p0_dir;
		logic [7:0] p1_dir;
		logic [7:0] p5_dir;
		logic [7:0] p0_dat;
		logic [7:0] p1_dat;
		logic [7:0] p5_dat;
		logic [7:0] p0_pu;
		logic [7:0] p1_pu;
		logic [7:0] p5_pu;
		logic [7:0] od;
	} mipb_regs_t;

	localparam mipb_regs_t REGS_RST = '{
		p0_dir: mipb_pkg::RST_DIRECTION,
		p1_dir: mipb_pkg::RST_DIRECTION,
		p5_dir: mipb_pkg::RST_DIRECTION,
		p0_dat: mipb_pkg::RST_DATA,
		p1_dat: mipb_pkg::RST_DATA,
		p5_dat: mipb_pkg::RST_DATA,
		p0_pu:  mipb_pkg::RST_PULLUP,
		p1_pu:  mipb_pkg::RST_PULLUP,
		p5_pu:  mipb_pkg::RST_PULLUP,
		od:     mipb_pkg::RST_OPEN_DRAIN
	};

	mipb_regs_t st_r;
	mipb_regs_t st_nxt;

	// ==========================================================================
	// Decoding helpers
	function automatic mipb_pkg::mipb_rid_t decode_rid(input logic [mipb_pkg::IDX_W-1:0] idx);
		mipb_pkg::mipb_rid_t rid;
		if (idx == mipb_pkg::IDX_PORT0_DIRECTION) begin
			rid = mipb_pkg::MIPB_RID_P0_DIR;
		end else if (idx == mipb_pkg::IDX_PORT1_DIRECTION) begin
			rid = mipb_pkg::MIPB_RID_P1_DIR;
		end else if (idx == mipb_pkg::IDX_PORT5_DIRECTION) begin
			rid = mipb_pkg::MIPB_RID_P5_DIR;
		end else if (idx == mipb_pkg::IDX_PORT0_DATA) begin
			rid = mipb_pkg::MIPB_RID_P0_DAT;
		end else if (idx == mipb_pkg::IDX_PORT1_DATA) begin
			rid = mipb_pkg::MIPB_RID_P1_DAT;
		end else if (idx == mipb_pkg::IDX_PORT5_DATA) begin
			rid = mipb_pkg::MIPB_RID_P5_DAT;
		end else if (idx == mipb_pkg::IDX_PORT0_PULLUP_ENABLE) begin
			rid = mipb_pkg::MIPB_RID_P0_PU;
		end else if (idx == mipb_pkg::IDX_PORT1_PULLUP_ENABLE) begin
			rid = mipb_pkg::MIPB_RID_P1_PU;
		end else if (idx == mipb_pkg::IDX_PORT5_PULLUP_ENABLE) begin
			rid = mipb_pkg::MIPB_RID_P5_PU;
		end else if (idx == mipb_pkg::IDX_OPEN_DRAIN_CONTROL) begin
			rid = mipb_pkg::MIPB_RID_OD;
		end else begin
			rid = mipb_pkg::MIPB_RID_NONE;
		end
		return rid;
	endfunction

	function automatic mipb_pkg::mipb_op_t decode_op(input logic [1:0] alias_sel);
		mipb_pkg::mipb_op_t op;
		if (alias_sel == mipb_pkg::ALIAS_PLAIN) begin
			op = mipb_pkg::MIPB_OP_WRITE;
		end else if (alias_sel == mipb_pkg::ALIAS_SET) begin
			op = mipb_pkg::MIPB_OP_SET;
		end else if (alias_sel == mipb_pkg::ALIAS_CLR) begin
			op = mipb_pkg::MIPB_OP_CLR;
		end else begin
			op = mipb_pkg::MIPB_OP_BAD;
		end
		return op;
	endfunction

	// Applies a plain write, a bit set or a bit clear, keeping only implemented bits.
	function automatic logic [7:0] apply_op(
		input logic [7:0]          cur,
		input logic [7:0]          val,
		input mipb_pkg::mipb_op_t  op,
		input logic [7:0]          mask
	);
		logic [7:0] res;
		case (op)
			mipb_pkg::MIPB_OP_SET: begin
				res = cur | val;
			end
			mipb_pkg::MIPB_OP_CLR: begin
				res = cur & ~val;
			end
			default: begin
				res = val;
			end
		endcase
		return res & mask;
	endfunction

	// ==========================================================================
	// Bus slave
	logic                            wr_en;
	logic [mipb_pkg::ADDR_W-1:0]     wr_addr;
	logic [mipb_pkg::DATA_W-1:0]     wr_data;
	logic [mipb_pkg::STRB_W-1:0]     wr_strb;
	logic                            wr_err;
	logic                            rd_en;
	logic [mipb_pkg::ADDR_W-1:0]     rd_addr;
	logic [mipb_pkg::DATA_W-1:0]     rd_data;
	logic                            rd_err;

	mipb_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// ==========================================================================
	// Write decode
	logic [mipb_pkg::IDX_W-1:0]  wr_idx;
	mipb_pkg::mipb_rid_t         wr_rid;
	mipb_pkg::mipb_op_t          wr_op;
	logic                        wr_is_bitop_target;
	logic [7:0]                  wr_byte;

	always_comb begin
		wr_idx  = wr_addr[mipb_pkg::ADDR_W-1:2];
		wr_rid  = decode_rid({2'h0, wr_idx[7:0]});
		wr_op   = decode_op(wr_idx[9:8]);
		wr_byte = wr_data[7:0];
		// Set and clear aliases exist for direction and data registers only.
		wr_is_bitop_target = (wr_rid == mipb_pkg::MIPB_RID_P0_DIR) ||
			(wr_rid == mipb_pkg::MIPB_RID_P1_DIR) ||
			(wr_rid == mipb_pkg::MIPB_RID_P5_DIR) ||
			(wr_rid == mipb_pkg::MIPB_RID_P0_DAT) ||
			(wr_rid == mipb_pkg::MIPB_RID_P1_DAT) ||
			(wr_rid == mipb_pkg::MIPB_RID_P5_DAT);
		wr_err = (wr_rid == mipb_pkg::MIPB_RID_NONE) ||
			(wr_op == mipb_pkg::MIPB_OP_BAD) ||
			((wr_op != mipb_pkg::MIPB_OP_WRITE) && !wr_is_bitop_target);
	end

	// ==========================================================================
	// Register update
	// Only byte lane 0 carries register bits; a write without it changes nothing.
	always_comb begin
		st_nxt = st_r;
		if (wr_en && !wr_err && wr_strb[0]) begin
			case (wr_rid)
				mipb_pkg::MIPB_RID_P0_DIR: begin
					st_nxt.p0_dir = apply_op(st_r.p0_dir, wr_byte, wr_op, mipb_pkg::MASK_PORT0);
				end
				mipb_pkg::MIPB_RID_P1_DIR: begin
					st_nxt.p1_dir = apply_op(st_r.p1_dir, wr_byte, wr_op, mipb_pkg::MASK_PORT1);
				end
				mipb_pkg::MIPB_RID_P5_DIR: begin
					st_nxt.p5_dir = apply_op(st_r.p5_dir, wr_byte, wr_op, mipb_pkg::MASK_PORT5);
				end
				mipb_pkg::MIPB_RID_P0_DAT: begin
					st_nxt.p0_dat = apply_op(st_r.p0_dat, wr_byte, wr_op, mipb_pkg::MASK_PORT0);
				end
				mipb_pkg::MIPB_RID_P1_DAT: begin
					// The input-only pin's data bit is outside the mask and cannot be written.
					st_nxt.p1_dat = apply_op(st_r.p1_dat, wr_byte, wr_op, mipb_pkg::MASK_PORT1);
				end
				mipb_pkg::MIPB_RID_P5_DAT: begin
					st_nxt.p5_dat = apply_op(st_r.p5_dat, wr_byte, wr_op, mipb_pkg::MASK_PORT5);
				end
				mipb_pkg::MIPB_RID_P0_PU: begin
					st_nxt.p0_pu = wr_byte & mipb_pkg::MASK_PORT0;
				end
				mipb_pkg::MIPB_RID_P1_PU: begin
					st_nxt.p1_pu = wr_byte & mipb_pkg::MASK_PORT1;
				end
				mipb_pkg::MIPB_RID_P5_PU: begin
					st_nxt.p5_pu = wr_byte & mipb_pkg::MASK_PORT5;
				end
				mipb_pkg::MIPB_RID_OD: begin
					st_nxt.od = wr_byte & mipb_pkg::MASK_OPEN_DRAIN;
				end
				default: begin
					st_nxt = st_r;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= REGS_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================================
	// Read path
	logic [mipb_pkg::IDX_W-1:0]  rd_idx;
	mipb_pkg::mipb_rid_t         rd_rid;
	logic [7:0]                  p1_pin_state;
	logic [7:0]                  rd_byte;

	always_comb begin
		rd_idx = rd_addr[mipb_pkg::ADDR_W-1:2];
		rd_rid = decode_rid(rd_idx);
		p1_pin_state = {2'h0, port1_pad_in} & {2'h0, mipb_pkg::PORT1_PINS'('1)};
		p1_pin_state[mipb_pkg::INPUT_ONLY_BIT] = ext_reset_option |
			port1_pad_in[mipb_pkg::INPUT_ONLY_BIT];
		rd_err  = 1'b0;
		rd_byte = 8'h00;
		case (rd_rid)
			mipb_pkg::MIPB_RID_P0_DIR: begin
				rd_byte = st_r.p0_dir;
			end
			mipb_pkg::MIPB_RID_P1_DIR: begin
				rd_byte = st_r.p1_dir;
				rd_byte[mipb_pkg::INPUT_ONLY_BIT] = 1'b1;
			end
			mipb_pkg::MIPB_RID_P5_DIR: begin
				rd_byte = st_r.p5_dir;
			end
			mipb_pkg::MIPB_RID_P0_DAT: begin
				rd_byte = {7'h00, port0_pad_in};
			end
			mipb_pkg::MIPB_RID_P1_DAT: begin
				rd_byte = p1_pin_state;
			end
			mipb_pkg::MIPB_RID_P5_DAT: begin
				rd_byte = port5_pad_in;
			end
			mipb_pkg::MIPB_RID_P0_PU, mipb_pkg::MIPB_RID_P1_PU, mipb_pkg::MIPB_RID_P5_PU,
			mipb_pkg::MIPB_RID_OD: begin
				// Write-only registers answer zero rather than an error.
				rd_byte = 8'h00;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
		rd_data = {24'h000000, rd_byte};
	end

	// ==========================================================================
	// Pin drivers
	// All driven pins are lined up as port 0 pin 0, port 1 pins 0 to 4, then port 5.
	logic [mipb_pkg::DRV_PINS-1:0] drv_dir;
	logic [mipb_pkg::DRV_PINS-1:0] drv_dat;
	logic [mipb_pkg::DRV_PINS-1:0] drv_pu;
	logic [mipb_pkg::DRV_PINS-1:0] drv_od;
	logic [mipb_pkg::DRV_PINS-1:0] drv_out;
	logic [mipb_pkg::DRV_PINS-1:0] drv_oe;
	logic [mipb_pkg::DRV_PINS-1:0] drv_pu_on;

	always_comb begin
		drv_dir = {st_r.p5_dir, st_r.p1_dir[4:0], st_r.p0_dir[0]};
		drv_dat = {st_r.p5_dat, st_r.p1_dat[4:0], st_r.p0_dat[0]};
		drv_pu  = {st_r.p5_pu, st_r.p1_pu[4:0], st_r.p0_pu[0]};
		drv_od  = '0;
		drv_od[mipb_pkg::OPEN_DRAIN_PIN] = st_r.od[mipb_pkg::OPEN_DRAIN_BIT];
	end

	genvar gi;
	generate
		for (gi = 0; gi < mipb_pkg::DRV_PINS; gi++) begin : g_pin
			mipb_pin_cell u_cell (
				.dir     (drv_dir[gi]),
				.dat     (drv_dat[gi]),
				.pu      (drv_pu[gi]),
				.od      (drv_od[gi]),
				.pad_out (drv_out[gi]),
				.pad_oe  (drv_oe[gi]),
				.pad_pu  (drv_pu_on[gi])
			);
		end
	endgenerate

	assign port0_pad_out   = drv_out[0];
	assign port0_pad_oe    = drv_oe[0];
	assign port0_pullup_on = drv_pu_on[0];
	assign port1_pad_out   = drv_out[5:1];
	assign port1_pad_oe    = drv_oe[5:1];
	assign port1_pullup_on = drv_pu_on[5:1];
	assign port5_pad_out   = drv_out[13:6];
	assign port5_pad_oe    = drv_oe[13:6];
	assign port5_pullup_on = drv_pu_on[13:6];

endmodule

`default_nettype wire

/* File: src/mipb_pin_cell.sv */
`timescale 1ns/10ps
`default_nettype none

module mipb_pin_cell (
	// Pin configuration
	input  wire logic dir,
	input  wire logic dat,
	input  wire logic pu,
	input  wire logic od,
	// Pad
	output logic      pad_out,
	output logic      pad_oe,
	output logic      pad_pu
);

	// ==========================================================================
	// Drive
	// An open-drain pin only ever drives low and lets the wire float for a one.
	always_comb begin
		pad_out = od ? 1'b0 : dat;
		pad_oe  = dir & (~od | ~dat);
		pad_pu  = pu;
	end

endmodule

`default_nettype wire

/* File: src/mipb_pkg.sv */
package mipb_pkg;

	// ==========================================================================
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned IDX_W  = 10;

	// ==========================================================================
	// Register indices; the byte address of each register is four times its index.
	localparam logic [IDX_W-1:0] IDX_PORT0_DIRECTION       = 10'h0B8;
	localparam logic [IDX_W-1:0] IDX_PORT1_DIRECTION       = 10'h0C1;
	localparam logic [IDX_W-1:0] IDX_PORT5_DIRECTION       = 10'h0C5;
	localparam logic [IDX_W-1:0] IDX_PORT0_DATA            = 10'h0D0;
	localparam logic [IDX_W-1:0] IDX_PORT1_DATA            = 10'h0D1;
	localparam logic [IDX_W-1:0] IDX_PORT5_DATA            = 10'h0D5;
	localparam logic [IDX_W-1:0] IDX_PORT0_PULLUP_ENABLE   = 10'h0E0;
	localparam logic [IDX_W-1:0] IDX_PORT1_PULLUP_ENABLE   = 10'h0E1;
	localparam logic [IDX_W-1:0] IDX_PORT5_PULLUP_ENABLE   = 10'h0E5;
	localparam logic [IDX_W-1:0] IDX_OPEN_DRAIN_CONTROL    = 10'h0E9;

	// Index bits [9:8] select the access kind: plain write, bit set or bit clear.
	localparam logic [1:0] ALIAS_PLAIN = 2'h0;
	localparam logic [1:0] ALIAS_SET   = 2'h1;
	localparam logic [1:0] ALIAS_CLR   = 2'h2;

	// ==========================================================================
	// Field layout
	localparam int unsigned PORT0_PINS       = 1;
	localparam int unsigned PORT1_PINS       = 6;
	localparam int unsigned PORT1_DRV_PINS   = 5;
	localparam int unsigned PORT5_PINS       = 8;
	localparam int unsigned DRV_PINS         = 14;
	localparam int unsigned INPUT_ONLY_BIT   = 5;
	localparam int unsigned OPEN_DRAIN_BIT   = 0;
	localparam int unsigned OPEN_DRAIN_PIN   = 1;
	localparam logic [7:0]  MASK_PORT0       = 8'h01;
	localparam logic [7:0]  MASK_PORT1       = 8'h1F;
	localparam logic [7:0]  MASK_PORT5       = 8'hFF;
	localparam logic [7:0]  MASK_OPEN_DRAIN  = 8'h01;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] RST_DIRECTION  = 8'h00;
	localparam logic [7:0] RST_DATA       = 8'h00;
	localparam logic [7:0] RST_PULLUP     = 8'h00;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;

	// ==========================================================================
	// Responses and enumerations
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MIPB_OP_WRITE, MIPB_OP_SET, MIPB_OP_CLR, MIPB_OP_BAD} mipb_op_t;

	typedef enum logic [3:0] {
		MIPB_RID_NONE,
		MIPB_RID_P0_DIR, MIPB_RID_P1_DIR, MIPB_RID_P5_DIR,
		MIPB_RID_P0_DAT, MIPB_RID_P1_DAT, MIPB_RID_P5_DAT,
		MIPB_RID_P0_PU,  MIPB_RID_P1_PU,  MIPB_RID_P5_PU,
		MIPB_RID_OD
	} mipb_rid_t;

endpackage

/* File: verification/mipb_io_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module mipb_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pads
	input wire logic [7:0]  port5_pad_oe,
	input wire logic [7:0]  port5_pullup_on
);
	// ==========
	// Bus and pad relations
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rd_busy_a: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	rd_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	rd_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
		else $error("write not answered");
	wr_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	wr_busy_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	rst_quiet_a: assert property (
		$rose(aresetn) |-> port5_pad_oe == 8'h00 && port5_pullup_on == 8'h00)
		else $error("pads active after reset");
endmodule
`default_nettype wire

/* File: verification/mipb_pins.sv */
`timescale 1ns/10ps
`default_nettype none
module mipb_pins #(
	parameter int W = 8
) (
	// Pad side
	input  wire logic [W-1:0] pad_out,
	input  wire logic [W-1:0] pad_oe,
	input  wire logic [W-1:0] pu_on,
	// Board side
	input  wire logic [W-1:0] board,
	output logic      [W-1:0] pad_in
);
	// ==========
	// Pin level
	// A driven pin wins; a released pin shows the pull-up or the board level.
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pu_on | board));
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        aclk, aresetn, ext_reset_option;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [0:0]  port0_pad_in, port0_pad_out, port0_pad_oe, port0_pullup_on, b0;
	logic [5:0]  port1_pad_in, b1;
	logic [4:0]  port1_pad_out, port1_pad_oe, port1_pullup_on;
	logic [7:0]  port5_pad_in, port5_pad_out, port5_pad_oe, port5_pullup_on, b5, d;
	int          fails, checked, i;
	// Direction 0..2, data 3..5, pull-up 6..8, open drain 9.
	localparam logic [11:0] A [10] = '{
		{mipb_pkg::IDX_PORT0_DIRECTION, 2'h0}, {mipb_pkg::IDX_PORT1_DIRECTION, 2'h0},
		{mipb_pkg::IDX_PORT5_DIRECTION, 2'h0}, {mipb_pkg::IDX_PORT0_DATA, 2'h0},
		{mipb_pkg::IDX_PORT1_DATA, 2'h0}, {mipb_pkg::IDX_PORT5_DATA, 2'h0},
		{mipb_pkg::IDX_PORT0_PULLUP_ENABLE, 2'h0}, {mipb_pkg::IDX_PORT1_PULLUP_ENABLE, 2'h0},
		{mipb_pkg::IDX_PORT5_PULLUP_ENABLE, 2'h0}, {mipb_pkg::IDX_OPEN_DRAIN_CONTROL, 2'h0}};
	mipb_io_port i_mipb_io_port (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ext_reset_option, .port0_pad_in, .port0_pad_out,
		.port0_pad_oe, .port0_pullup_on, .port1_pad_in, .port1_pad_out, .port1_pad_oe,
		.port1_pullup_on, .port5_pad_in, .port5_pad_out, .port5_pad_oe, .port5_pullup_on);
	mipb_pins #(.W(1)) i_mipb_pins0 (.pad_out(port0_pad_out), .pad_oe(port0_pad_oe),
		.pu_on(port0_pullup_on), .board(b0), .pad_in(port0_pad_in));
	mipb_pins #(.W(6)) i_mipb_pins1 (.pad_out({1'b0, port1_pad_out}),
		.pad_oe({1'b0, port1_pad_oe}), .pu_on({1'b0, port1_pullup_on}), .board(b1),
		.pad_in(port1_pad_in));
	mipb_pins #(.W(8)) i_mipb_pins5 (.pad_out(port5_pad_out), .pad_oe(port5_pad_oe),
		.pu_on(port5_pullup_on), .board(b5), .pad_in(port5_pad_in));
	always #20 aclk = ~aclk;
	// ==========
	// Bus tasks
	task automatic complete_run();
		$display("Counts: %0d checked, %0d failed", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	task automatic hang();
		fails++;
		$display("Error at %0t: bus timeout", $time);
		complete_run();
	endtask
	// Ready rises only once valid is seen, so the slave must hold its answer.
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic ta, tw, tb, sb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid && s_axi_bready;
			sb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				return;
			end else if (sb) s_axi_bready <= 1'b1;
		end
		hang();
	endtask
	task automatic rd(input logic [11:0] a);
		logic ta, tr, sv;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			sv = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				return;
			end else if (sv) s_axi_rready <= 1'b1;
		end
		hang();
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		rd(a);
		chk(d, e);
		chk(r, mipb_pkg::RESP_OKAY);
	endtask
	// ==========
	// Tests
	initial begin
		aclk = 1'b0;
		{aresetn, ext_reset_option, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{b0, b1, b5} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 10; i++) begin
			rc(A[i], (i == 1) ? 8'h20 : 8'h00);
		end
		chk({port0_pad_oe, port1_pad_oe, port5_pad_oe, port5_pullup_on}, 32'h0);
		$display("Test reset done");
		wr(A[0], 8'hFF);
		rc(A[0], 8'h01);
		wr(A[1], 8'h01);
		rc(A[1], 8'h21);
		b5 <= 8'h96;
		wr(A[2], 8'hFF);
		wr(A[3], 8'hFF);
		wr(A[5], 8'hA5);
		chk({port0_pad_out, port5_pad_oe, port5_pad_out}, 17'h1FFA5);
		rc(A[5], 8'hA5);
		wr({mipb_pkg::ALIAS_CLR, A[2][9:0]}, 8'h0F);
		wr({mipb_pkg::ALIAS_SET, A[2][9:0]}, 8'h01);
		rc(A[2], 8'hF1);
		wr({mipb_pkg::ALIAS_SET, A[5][9:0]}, 8'h40);
		wr({mipb_pkg::ALIAS_CLR, A[5][9:0]}, 8'h05);
		rc(A[5], 8'hE6);
		wr({mipb_pkg::ALIAS_CLR, A[2][9:0]}, 8'hFF);
		wr(A[5], 8'h3C);
		chk(port5_pad_oe, 8'h00);
		rc(A[5], 8'h96);
		wr({mipb_pkg::ALIAS_SET, A[2][9:0]}, 8'hFF);
		chk(port5_pad_out, 8'h3C);
		$display("Test direction and data done");
		b5 <= 8'h00;
		wr(A[2], 8'h00);
		wr(A[8], 8'h81);
		chk(port5_pullup_on, 8'h81);
		rc(A[5], 8'h81);
		rc(A[8], 8'h00);
		wr(A[7], 8'hFF);
		chk(port1_pullup_on, 5'h1F);
		$display("Test pull-up done");
		wr(A[9], 8'h01);
		wr(A[4], 8'h01);
		chk(port1_pad_oe[0], 1'b0);
		wr(A[4], 8'h00);
		chk({r, port1_pad_oe, port1_pad_out}, 12'h020);
		ext_reset_option <= 1'b1;
		rc(A[4], 8'h3E);
		ext_reset_option <= 1'b0;
		rc(A[4], 8'h1E);
		wr(12'h2E4, 8'h01);
		chk(r, mipb_pkg::RESP_SLVERR);
		$display("Test open drain and errors done");
		complete_run();
	end
endmodule
bind mipb_io_port mipb_chk i_mipb_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port5_pad_oe,
	.port5_pullup_on);
`default_nettype wire
